/* File: dv/dtsl_bus_model.sv */
// Model of the bus watch logic that feeds compare results and capture words.
module dtsl_bus_model
  import dtsl_pkg::*;
(
  // Clock
  input  wire logic        i_clk,
  // Towards the block
  output dtsl_cmp_s        o_cmp,
  output logic             o_bus_valid,
  output logic      [15:0] o_bus_addr,
  output logic      [7:0]  o_bus_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cmp       = '0;
    o_bus_valid = 1'b0;
    o_bus_addr  = 16'h0000;
    o_bus_data  = 8'h00;
  end

  // Holds one compare result for n cycles while the bus word moves on every cycle.
  // Released words show their inverse so that a stale word never passes for a fresh one.
  task automatic ev(input dtsl_cmp_s c, input logic v, input int n);
    @(posedge i_clk);
    o_cmp       <= c;
    o_bus_valid <= v;
    for (int k = 0; k < n; k++) begin
      o_bus_addr <= 16'h1000 + 16'(k);
      o_bus_data <= 8'h5a + 8'(k);
      @(posedge i_clk);
    end
    o_cmp       <= '0;
    o_bus_valid <= 1'b0;
    o_bus_addr  <= ~o_bus_addr;
    o_bus_data  <= ~o_bus_data;
  endtask
endmodule

/* File: dv/tb.sv */
// Self-checking testbench for the debug trigger selection and status logic.
module tb
  import dtsl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        i_clk       = 1'b0;
  logic        i_resetn    = 1'b0;
  logic        i_psel      = 1'b0;
  logic        i_penable   = 1'b0;
  logic        i_pwrite    = 1'b0;
  logic [11:0] i_paddr     = 12'h000;
  logic [31:0] i_pwdata    = 32'h0;
  logic        i_host_stop = 1'b0;
  dtsl_cmp_s   i_cmp;
  logic        i_bus_valid;
  logic [15:0] i_bus_addr;
  logic [7:0]  i_bus_data;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_store, o_break_req, o_run_active;
  logic [15:0] o_store_word;
  logic [31:0] rd;
  logic        err;
  logic        ev_only     = 1'b0;
  int          error_cnt   = 0;
  int          n_tests     = 0;
  int          n_store     = 0;
  int          n_brk       = 0;
  // Outside range runs tagged, since an idle bus already lies outside the range.
  localparam logic [7:0] TRG [8] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h88, 8'h80};
  localparam logic [5:0] MISS [8] = '{6'h10, 6'h0e, 6'h20, 6'h20, 6'h28, 6'h04, 6'h07, 6'h20};
  localparam logic [5:0] HIT [8] = '{6'h20, 6'h10, 6'h10, 6'h28, 6'h20, 6'h06, 6'h03, 6'h21};

  always #25 i_clk = ~i_clk;

  dtsl_bus_model bm (.i_clk, .o_cmp(i_cmp), .o_bus_valid(i_bus_valid),
                     .o_bus_addr(i_bus_addr), .o_bus_data(i_bus_data));
  dtsl_top uut (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
                .o_prdata, .o_pready, .o_pslverr, .i_cmp, .i_bus_valid, .i_bus_addr,
                .i_bus_data, .i_host_stop, .o_store, .o_store_word, .o_break_req,
                .o_run_active);

  // Counting at the falling edge keeps clear of the registered updates.
  always @(negedge i_clk) begin
    if (o_store === 1'b1) begin
      n_store++;
      if (ev_only) check(o_store_word[15:8], 8'h00);
    end
    if (o_break_req === 1'b1) n_brk++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The request stands until pready is seen at a rising edge; only the watchdog ends a hang.
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= a;
    i_pwdata  <= {24'h000000, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd        = o_prdata;
    err       = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    check(rd, exp);
  endtask

  task automatic stchk(input logic armed);
    apb(1'b0, DTSL_OFS_STATUS, 8'h00);
    check(rd[5], armed);
  endtask

  task automatic arm(input logic [7:0] t);
    apb(1'b1, DTSL_OFS_TRIG, t);
    apb(1'b1, DTSL_OFS_CTRL, 8'hd0);
  endtask

  task automatic idle;
    repeat (4) @(posedge i_clk);
  endtask

  initial begin
    #400us;
    error_cnt++;
    give_verdict;
  end

  initial begin
    int s0;
    int b0;
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    rdchk(DTSL_OFS_CTRL, 32'h0);
    rdchk(DTSL_OFS_STATUS, 32'h0);
    rdchk(12'h00c, 32'h0);
    check(err, 1'b1);
    apb(1'b1, DTSL_OFS_TRIG, 8'hff);
    rdchk(DTSL_OFS_TRIG, 32'hcf);
    apb(1'b1, DTSL_OFS_STATUS, 8'hff);
    rdchk(DTSL_OFS_STATUS, 32'h0);
    apb(1'b1, DTSL_OFS_CTRL, 8'hd0);
    stchk(1'b1);
    check(o_run_active, 1'b1);
    bm.ev(6'h36, 1'b0, 2);
    idle;
    stchk(1'b1);
    apb(1'b1, DTSL_OFS_TRIG, 8'h00);
    rdchk(DTSL_OFS_TRIG, 32'hcf);
    apb(1'b1, DTSL_OFS_CTRL, 8'h90);
    stchk(1'b0);
    arm(8'h09);
    apb(1'b1, DTSL_OFS_CTRL, 8'h50);
    idle;
    check(o_run_active, 1'b0);
    arm(8'h09);
    i_host_stop <= 1'b1;
    idle;
    idle;
    check(o_run_active, 1'b0);
    i_host_stop <= 1'b0;
    apb(1'b1, DTSL_OFS_CTRL, 8'h90);
    for (int i = 0; i < 8; i++) begin
      arm(TRG[i]);
      bm.ev(MISS[i], 1'b0, 1);
      idle;
      stchk(1'b1);
      b0 = n_brk;
      bm.ev(HIT[i], 1'b0, 1);
      idle;
      stchk(1'b0);
      rdchk(DTSL_OFS_CTRL, 32'h90);
      check(n_brk, b0 + 1);
    end
    arm(8'h00);
    s0 = n_store;
    bm.ev(6'h00, 1'b1, 10);
    bm.ev(6'h20, 1'b0, 1);
    idle;
    check(n_store - s0, 10);
    rdchk(DTSL_OFS_STATUS, 32'h88);
    rdchk(DTSL_OFS_STATUS, 32'h88);
    ev_only = 1'b1;
    for (int i = 0; i < 2; i++) begin
      arm(i == 0 ? 8'h03 : 8'h04);
      rdchk(DTSL_OFS_STATUS, 32'h20);
      s0 = n_store;
      b0 = n_brk;
      bm.ev(i == 0 ? 6'h00 : 6'h10, 1'b1, 3);
      if (i == 1) bm.ev(6'h20, 1'b0, 1);
      idle;
      check(n_store, s0);
      bm.ev(6'h10, 1'b0, 8);
      idle;
      check(n_store - s0, 8);
      rdchk(DTSL_OFS_STATUS, i == 0 ? 32'h48 : 32'hc8);
      check(n_brk, b0 + 1);
    end
    give_verdict;
  end
endmodule

/* File: hdl/dtsl_pkg.sv */
// Package with register map, field positions, modes and carriers for the debug trigger logic.
package dtsl_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] DTSL_OFS_CTRL   = 12'h000;
  localparam logic [11:0] DTSL_OFS_TRIG   = 12'h004;
  localparam logic [11:0] DTSL_OFS_STATUS = 12'h008;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int DTSL_CTRL_EN    = 7;
  localparam int DTSL_CTRL_ARM   = 6;
  localparam int DTSL_CTRL_BREAK_REQUEST_ENABLE = 4;
  localparam int DTSL_TRIG_QUAL  = 7;
  localparam int DTSL_TRIG_BEGIN = 6;
  localparam logic [7:0] DTSL_TRIG_WMASK = 8'hcf;
  localparam logic [7:0] DTSL_RESET_BYTE = 8'h00;
  localparam logic [3:0] DTSL_FIFO_DEPTH = 4'h8;
  localparam logic [3:0] DTSL_CNT_ONE    = 4'h1;

  // ---------------------------------------------------------------------------
  // Trigger modes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    DTSL_M_A_ONLY   = 4'b0000,
    DTSL_M_A_OR_B   = 4'b0001,
    DTSL_M_A_THEN_B = 4'b0010,
    DTSL_M_EV_B     = 4'b0011,
    DTSL_M_A_EV_B   = 4'b0100,
    DTSL_M_A_AND_D  = 4'b0101,
    DTSL_M_A_NAND_D = 4'b0110,
    DTSL_M_INSIDE   = 4'b0111,
    DTSL_M_OUTSIDE  = 4'b1000
  } dtsl_mode_e;

  // Comparator results from the bus watch logic.
  typedef struct packed {
    logic a_hit;
    logic b_hit;
    logic b_data_hit;
    logic addr_ge_a;
    logic addr_le_b;
    logic exec;
  } dtsl_cmp_s;

endpackage

/* File: hdl/dtsl_sync.sv */
// Three-stage synchroniser with agreement filter for external debug inputs.
module dtsl_sync
  import dtsl_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Data
  input  wire logic i_d,
  output logic      o_q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_q  <= 1'b0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_q <= s3_r;
      end
    end
  end

endmodule

/* File: hdl/dtsl_top.sv */
// Debug trigger selection and status logic with APB register access.
module dtsl_top
  import dtsl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Comparator results and capture request from the bus watch logic
  input  wire dtsl_cmp_s   i_cmp,
  input  wire logic        i_bus_valid,
  input  wire logic [15:0] i_bus_addr,
  input  wire logic [7:0]  i_bus_data,
  // External debug host stop request, asynchronous
  input  wire logic        i_host_stop,
  // Capture and break outputs
  output logic             o_store,
  output logic      [15:0] o_store_word,
  output logic             o_break_req,
  output logic             o_run_active
);

  // ---------------------------------------------------------------------------
  // Registers and decode
  // ---------------------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] trig_r;
  logic       af_r;
  logic       bf_r;
  logic       run_active_flag_r;
  logic [3:0] cnt_r;
  logic       seen_a_r;
  logic       started_r;
  logic       host_stop;
  logic       acc;
  logic       wr_ctrl;
  logic       wr_trig;
  logic [7:0] ctrl_nxt;
  logic [7:0] status;

  dtsl_sync u_stop_sync (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_d      (i_host_stop),
    .o_q      (host_stop)
  );

  assign acc     = i_psel && i_penable;
  assign wr_ctrl = acc && i_pwrite && (i_paddr == DTSL_OFS_CTRL);
  assign wr_trig = acc && i_pwrite && (i_paddr == DTSL_OFS_TRIG);
  assign status  = {af_r, bf_r, run_active_flag_r, 1'b0, cnt_r};

  // ---------------------------------------------------------------------------
  // Trigger decode
  // ---------------------------------------------------------------------------
  logic       qual;
  logic       a_q;
  logic       b_q;
  logic       event_only;
  logic       begin_mode;
  logic       trig_hit;
  logic       ev_store;
  logic       cap;
  logic       full_next;
  logic       done;
  dtsl_mode_e mode;

  assign mode = dtsl_mode_e'(trig_r[3:0]);
  // Tag mode only lets a match through once the opcode really executes.
  assign qual = !trig_r[DTSL_TRIG_QUAL] || i_cmp.exec;
  assign a_q  = i_cmp.a_hit && qual;
  assign b_q  = i_cmp.b_hit && qual;
  assign event_only = (mode == DTSL_M_EV_B) || (mode == DTSL_M_A_EV_B);
  assign begin_mode = trig_r[DTSL_TRIG_BEGIN] || event_only;

  always_comb begin
    trig_hit = 1'b0;
    ev_store = 1'b0;
    unique case (trig_r[3:0])
      DTSL_M_A_ONLY:   trig_hit = a_q;
      DTSL_M_A_OR_B:   trig_hit = a_q || b_q;
      DTSL_M_A_THEN_B: trig_hit = seen_a_r && b_q;
      DTSL_M_EV_B:     ev_store = b_q;
      DTSL_M_A_EV_B:   ev_store = (seen_a_r || a_q) && b_q;
      DTSL_M_A_AND_D:  trig_hit = a_q && i_cmp.b_data_hit;
      DTSL_M_A_NAND_D: trig_hit = a_q && !i_cmp.b_data_hit;
      DTSL_M_INSIDE:   trig_hit = qual && i_cmp.addr_ge_a && i_cmp.addr_le_b;
      DTSL_M_OUTSIDE:  trig_hit = qual && !(i_cmp.addr_ge_a && i_cmp.addr_le_b);
      default:         trig_hit = 1'b0;
    endcase
  end

  // Begin trace stores from the trigger cycle on; end trace stores circularly until it.
  assign cap = run_active_flag_r && (event_only ? ev_store :
               (begin_mode ? (started_r || trig_hit) : i_bus_valid));
  assign full_next = cap && (cnt_r == DTSL_FIFO_DEPTH - DTSL_CNT_ONE);
  assign done = run_active_flag_r && (begin_mode ? full_next : trig_hit);

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = i_pwdata[7:0];
    end
    // Completion and host stop drop the arm bit; a same-cycle write loses.
    if (done || host_stop) begin
      ctrl_nxt[DTSL_CTRL_ARM] = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= DTSL_RESET_BYTE;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Trigger configuration register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trig_r <= DTSL_RESET_BYTE;
    end else if (wr_trig && !ctrl_r[DTSL_CTRL_ARM]) begin
      trig_r <= i_pwdata[7:0] & DTSL_TRIG_WMASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Run state and status
  // ---------------------------------------------------------------------------
  logic arm_start;
  assign arm_start = wr_ctrl && i_pwdata[DTSL_CTRL_ARM] && i_pwdata[DTSL_CTRL_EN]
                     && !host_stop;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_active_flag_r <= 1'b0;
    end else begin
      // Armed flag follows the arm bit only while the module is enabled.
      run_active_flag_r <= ctrl_nxt[DTSL_CTRL_ARM] && ctrl_nxt[DTSL_CTRL_EN];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      seen_a_r <= 1'b0;
    end else if (arm_start && !run_active_flag_r) begin
      af_r     <= 1'b0;
      bf_r     <= 1'b0;
      seen_a_r <= 1'b0;
    end else if (run_active_flag_r) begin
      af_r     <= af_r || a_q;
      bf_r     <= bf_r || b_q;
      seen_a_r <= seen_a_r || a_q;
    end
  end

  // Count saturates at depth: the FIFO keeps the latest eight in end trace.
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r     <= 4'h0;
      started_r <= 1'b0;
    end else if (arm_start && !run_active_flag_r) begin
      cnt_r     <= 4'h0;
      started_r <= 1'b0;
    end else if (run_active_flag_r) begin
      if (cap && cnt_r != DTSL_FIFO_DEPTH) begin
        cnt_r <= cnt_r + DTSL_CNT_ONE;
      end
      started_r <= started_r || (begin_mode && trig_hit);
    end
  end

  // ---------------------------------------------------------------------------
  // Capture and break outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_store      <= 1'b0;
      o_store_word <= 16'h0000;
      o_break_req  <= 1'b0;
      o_run_active <= 1'b0;
    end else begin
      o_store      <= cap;
      // Event-only words carry data in the low byte; the high byte stays unused.
      o_store_word <= event_only ? {8'h00, i_bus_data} : i_bus_addr;
      o_break_req  <= done && ctrl_r[DTSL_CTRL_BREAK_REQUEST_ENABLE];
      o_run_active <= run_active_flag_r;
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave, zero wait states
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !(i_paddr == DTSL_OFS_CTRL ||
                   i_paddr == DTSL_OFS_TRIG || i_paddr == DTSL_OFS_STATUS);
      o_prdata  <= 32'h0000_0000;
      if (i_psel && !i_penable && !i_pwrite) begin
        unique case (i_paddr)
          DTSL_OFS_CTRL:   o_prdata <= {24'h000000, ctrl_r};
          DTSL_OFS_TRIG:   o_prdata <= {24'h000000, trig_r};
          DTSL_OFS_STATUS: o_prdata <= {24'h000000, status};
          default:         o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  chk_trig_write_lock: assert property (
    ctrl_r[DTSL_CTRL_ARM] |=> $stable(trig_r))
    else $error("Trigger register changed while armed.");

  chk_trig_zero_bits: assert property (trig_r[5:4] == 2'b00)
    else $error("Trigger bits 4 and 5 not zero.");

  chk_status_read_only: assert property (
    wr_ctrl == 1'b0 && i_paddr == DTSL_OFS_STATUS && acc && i_pwrite
    |=> $stable(cnt_r) || $past(run_active_flag_r))
    else $error("Status write had an effect.");

  chk_flags_clear_arm: assert property (
    arm_start && !run_active_flag_r |=> !af_r && !bf_r && cnt_r == 4'h0)
    else $error("Flags not cleared at run start.");

  chk_armed_mirror: assert property (
    run_active_flag_r == (ctrl_r[DTSL_CTRL_ARM] && ctrl_r[DTSL_CTRL_EN]))
    else $error("Armed flag does not mirror arm bit.");

  chk_done_disarms: assert property (done |=> !run_active_flag_r && !ctrl_r[DTSL_CTRL_ARM])
    else $error("Run did not end on completion.");

  chk_stop_disarms: assert property (host_stop |=> !run_active_flag_r)
    else $error("Host stop did not end the run.");

  chk_count_bound: assert property (cnt_r <= DTSL_FIFO_DEPTH)
    else $error("Valid count above depth.");

  chk_count_hold: assert property (!run_active_flag_r && !arm_start |=> $stable(cnt_r))
    else $error("Valid count changed outside a run.");

  chk_break_req: assert property (
    done && ctrl_r[DTSL_CTRL_BREAK_REQUEST_ENABLE] |=> o_break_req)
    else $error("Break request missing.");

  // ---------------------------------------------------------------------------
  // Decode and capture checks
  // ---------------------------------------------------------------------------
  // The tag, unused-code and inside-range checks watch the decode before run gating, so a stray hit shows up early.
  chk_tag_gate: assert property (
    trig_r[DTSL_TRIG_QUAL] && !i_cmp.exec |-> !trig_hit && !ev_store)
    else $error("Untagged match passed tag qualification.");

  chk_event_run_len: assert property (
    run_active_flag_r && event_only && !full_next |-> !done)
    else $error("Event-only run ended before the capture was full.");

  chk_no_trigger_high: assert property (
    trig_r[3:0] > DTSL_M_OUTSIDE |-> !trig_hit && !ev_store)
    else $error("Unused trigger code produced a trigger.");

  chk_event_store: assert property (
    run_active_flag_r && mode == DTSL_M_EV_B && b_q |=> o_store)
    else $error("Event B did not store a word.");

  chk_range_inside: assert property (
    !trig_r[DTSL_TRIG_QUAL] && mode == DTSL_M_INSIDE
    && i_cmp.addr_ge_a && i_cmp.addr_le_b |-> trig_hit)
    else $error("Inside range access did not trigger.");

  chk_a_flag_set: assert property (
    run_active_flag_r && a_q |=> af_r)
    else $error("A flag not set after an A match.");

  chk_b_flag_set: assert property (
    run_active_flag_r && b_q |=> bf_r)
    else $error("B flag not set after a B match.");

  chk_count_step: assert property (
    run_active_flag_r && cap && cnt_r != DTSL_FIFO_DEPTH |=> cnt_r == $past(cnt_r) + DTSL_CNT_ONE)
    else $error("Valid count did not follow a stored word.");

  chk_event_word: assert property (
    o_store && $past(event_only) |-> o_store_word[15:8] == 8'h00)
    else $error("Event-only word has a used high byte.");

  chk_break_cause: assert property (
    o_break_req |-> $past(done))
    else $error("Break request without a completed run.");

  cov_end_trace:   cover property (run_active_flag_r && !begin_mode ##[1:20] done);
  cov_begin_full:  cover property (run_active_flag_r && begin_mode ##[1:40] cnt_r == DTSL_FIFO_DEPTH);
  cov_event_only:  cover property (run_active_flag_r && event_only && ev_store);
  cov_manual_stop: cover property (run_active_flag_r ##1 host_stop);
  cov_tag_block:   cover property (run_active_flag_r && trig_r[DTSL_TRIG_QUAL] && i_cmp.a_hit && !i_cmp.exec);

endmodule
